// file: core/return_interrupt_and_config_load_ops.sv
`timescale 1ns/10ps
`default_nettype none
`include "retcfg_consts.svh"

module return_interrupt_and_config_load_ops
   import retcfg_pkg::*;
#(
   parameter int STACK_DEPTH = `STACK_DEPTH
)
(
   input wire logic clk, // 100 MHz core clock
   input wire logic rst, // Async reset, active high
   input wire instr_t instr, // Fetched word for this cycle
   input wire logic [7:0] w_reg, // Working register value
   input wire file_access_t file_acc, // Ordinary data register access
   input wire pc_ctrl_t pc_in, // Sequential PC and call push request
   output logic [12:0] pc, // Program counter
   output logic [7:0] cfg_reg, // Core configuration register
   output logic [7:0] irq_control_reg, // Interrupt control register
   output logic global_irq_enable, // Global interrupt enable
   output logic [7:0] file_rdata, // Read data for config address
   output logic file_hit, // Access addresses config register
   output logic [12:0] stack_top, // Current top of return stack
   output logic instr_done, // Instruction retired this cycle
   output logic flush // Fetched word discarded
);

   // ==========================================
   // State
   // Instruction cycle is four clocks, q1 to q4
   // q3: interrupt return sets the enable bit
   // q4: pops, loads, direct writes and pushes land
   // Flush cycle: four idle clocks, then pc steps past the return address
   // Block state other than the return stack, registered as one word
   typedef struct packed {
      qphase_t q;
      exec_state_t st;
      logic [12:0] pc;
      logic [7:0] cfg;
      logic [7:0] intc;
      logic [`STACK_PTR_WIDTH-1:0] sp;
      logic [7:0] rdata;
      logic done;
   } state_t;

   state_t cur, next_cur;
   // Return addresses; a ninth push wraps and overwrites the oldest entry
   logic [12:0] stack [STACK_DEPTH];
   // Push strobe, one clock wide at q4 of a plain instruction
   logic stk_push;
   // Entry one below the pointer, the current top
   logic [`STACK_PTR_WIDTH-1:0] sp_below;
   logic op_ret;
   logic op_load;

   // ==========================================
   // Decode helpers
   // Valid word matching one opcode
   function automatic logic is_op(input instr_t i, input logic [13:0] opc);
      return i.valid && (i.word == opc);
   endfunction : is_op

   // Data access aimed at the config register
   function automatic logic cfg_hit(input file_access_t f, input logic want_rd, input logic want_wr);
      return ((want_rd && f.rd) || (want_wr && f.wr)) && (f.addr == `CFG_REG_ADDR);
   endfunction : cfg_hit

   // ==========================================
   // Next state
   always_comb
   begin
      // Default: hold state, drop the retire pulse
      next_cur = cur;
      next_cur.done = 1'b0;
      stk_push = 1'b0;
      // Phase counter wraps q4 back to q1
      next_cur.q = qphase_t'(cur.q + 2'd1);
      // Read data tracks the register every clock the read is held
      if (cfg_hit(file_acc, 1'b1, 1'b0))
      begin
         next_cur.rdata = cur.cfg;
      end
      // Direct write lands at q4; a config-load in the same cycle overrides it
      if (cfg_hit(file_acc, 1'b0, 1'b1) && cur.q == q4)
      begin
         next_cur.cfg = file_acc.wdata;
      end
      case (cur.st)
         st_exec:
         begin
            // Interrupt return: enable at q3, pop at q4
            if (op_ret)
            begin
               if (cur.q == q3)
               begin
                  // Only the enable bit moves; no other flag is touched
                  next_cur.intc[`IRQ_CTRL_ENABLE_BIT] = 1'b1;
               end
               if (cur.q == q4)
               begin
                  // Pop: take the top entry, then drop the pointer
                  next_cur.pc = stack[sp_below];
                  next_cur.sp = sp_below;
                  next_cur.st = st_flush;
               end
            end
            // Config load: single cycle, status flags untouched
            else if (op_load)
            begin
               if (cur.q == q4)
               begin
                  next_cur.cfg = w_reg;
                  next_cur.pc = pc_in.pc;
                  next_cur.done = 1'b1;
               end
            end
            // Any other word: advance, and push a return address on request
            else if (cur.q == q4)
            begin
               next_cur.pc = pc_in.pc;
               next_cur.done = 1'b1;
               if (pc_in.push)
               begin
                  stk_push = 1'b1;
                  next_cur.sp = cur.sp + 1'b1;
               end
            end
         end
         st_flush:
         begin
            // Word fetched from the old pc is discarded here
            if (cur.q == q4)
            begin
               next_cur.pc = cur.pc + 13'd1;
               next_cur.st = st_exec;
               next_cur.done = 1'b1;
            end
         end
         default:
         begin
            // Recover from an illegal state code
            next_cur.st = st_exec;
         end
      endcase
   end

   // ==========================================
   // Registers
   // All state but the stack entries registered at once
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         // Stack entries themselves have no reset
         cur <= '{
            q: q1,
            st: st_exec,
            pc: `PC_RESET,
            cfg: `CFG_REG_RESET,
            intc: `IRQ_CTRL_RESET,
            sp: '0,
            rdata: 8'h00,
            done: 1'b0
         };
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // ==========================================
   // Return stack storage
   // One writer per entry; an entry reads unknown until first pushed
   // Pushes during interrupt return or config load are ignored
   genvar gi;
   generate
      for (gi = 0; gi < STACK_DEPTH; gi++)
      begin : g_stack
         always_ff @(posedge clk)
         begin
            if (stk_push && cur.sp == `STACK_PTR_WIDTH'(gi))
            begin
               stack[gi] <= pc_in.push_value;
            end
         end
      end
   endgenerate

   // Pointer arithmetic wraps modulo the stack depth
   assign sp_below = cur.sp - 1'b1;

   // ==========================================
   // Opcode decode
   // Both opcodes need a valid word; invalid words advance like any other word, pushing on request
   assign op_ret = is_op(instr, `OPC_IRQ_RETURN);
   assign op_load = is_op(instr, `OPC_CFG_LOAD);

   // ==========================================
   // Outputs
   assign pc = cur.pc;
   assign cfg_reg = cur.cfg;
   assign irq_control_reg = cur.intc;
   assign global_irq_enable = cur.intc[`IRQ_CTRL_ENABLE_BIT];
   assign file_rdata = cur.rdata;
   // Address hit is combinational; data outputs come from flip-flops
   assign file_hit = cfg_hit(file_acc, 1'b1, 1'b1);
   // Unknown until the first push
   assign stack_top = stack[sp_below];
   assign instr_done = cur.done;
   assign flush = (cur.st == st_flush);

endmodule : return_interrupt_and_config_load_ops
`default_nettype wire

// file: core/retcfg_consts.svh
`ifndef RETCFG_CONSTS_SVH
`define RETCFG_CONSTS_SVH

// Instruction encodings
`define OPC_IRQ_RETURN 14'h0009
`define OPC_CFG_LOAD 14'h0062

// Interrupt control register layout
`define IRQ_CTRL_ENABLE_BIT 7
`define IRQ_CTRL_RESET 8'h00

// Core configuration register
`define CFG_REG_ADDR 7'h01
`define CFG_REG_RESET 8'hff

// Stack and program counter
`define PC_WIDTH 13
`define STACK_DEPTH 8
`define STACK_PTR_WIDTH 3
`define PC_RESET 13'h0000

// Quarter-phase count per instruction cycle
`define Q_PHASES 4

`endif

// file: core/retcfg_pkg.sv
package retcfg_pkg;

   typedef enum logic [1:0] {q1, q2, q3, q4} qphase_t;

   typedef enum {st_exec, st_flush} exec_state_t;

   typedef struct packed {
      logic [13:0] word;
      logic valid;
   } instr_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } file_access_t;

   typedef struct packed {
      logic [12:0] pc;
      logic push;
      logic [12:0] push_value;
   } pc_ctrl_t;

endpackage : retcfg_pkg

// file: tb/retcfg_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "retcfg_consts.svh"
module retcfg_asserts
   import retcfg_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire instr_t instr, // Word
   input wire logic [7:0] w_reg, // W
   input wire file_access_t file_acc, // Access
   input wire logic [12:0] pc, // Pc
   input wire logic [7:0] cfg_reg, // Cfg
   input wire logic [7:0] irq_control_reg, // Irq
   input wire logic [7:0] file_rdata, // Rdata
   input wire logic [12:0] stack_top, // Top
   input wire logic instr_done, // Done
   input wire logic flush // Flush
);
   // ====
   // Phase tracking
   logic [1:0] ph;
   logic ret;
   logic ld;
   assign ret = instr.valid && instr.word == `OPC_IRQ_RETURN && !flush;
   assign ld = instr.valid && instr.word == `OPC_CFG_LOAD && !flush;
   always_ff @(posedge clk or posedge rst)
      if (rst) ph <= 2'h0;
      else ph <= ph + 2'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_ret_pops_top: assert property (ph == 2'h3 && ret |=> pc == $past(stack_top))
      else $error("pc not top");
   chk_ret_sets_enable: assert property (ph == 2'h2 && ret |=> irq_control_reg[`IRQ_CTRL_ENABLE_BIT])
      else $error("irq enable not set");
   chk_ret_two_cycles: assert property (ph == 2'h3 && ret |=> flush [*4] ##1 (!flush && instr_done))
      else $error("flush length");
   chk_cfg_load_copy: assert property (ph == 2'h3 && ld |=> instr_done && cfg_reg == $past(w_reg))
      else $error("cfg load");
   chk_cfg_file_write: assert property (
      ph == 2'h3 && !ld && file_acc.wr && file_acc.addr == `CFG_REG_ADDR |=> cfg_reg == $past(file_acc.wdata))
      else $error("cfg write");
   chk_cfg_file_read: assert property (
      ph != 2'h3 && file_acc.rd && file_acc.addr == `CFG_REG_ADDR |=> file_rdata == $past(cfg_reg))
      else $error("cfg read");
   chk_ret_no_flags: assert property (ph == 2'h3 && ret |=> irq_control_reg[6:0] == $past(irq_control_reg[6:0]))
      else $error("flags moved");
   cover property (ph == 2'h3 && ret);
   cover property (ph == 2'h3 && ld);
   cover property (ph == 2'h3 && file_acc.wr);
endmodule : retcfg_asserts
bind return_interrupt_and_config_load_ops retcfg_asserts chk (.clk, .rst, .instr, .w_reg, .file_acc, .pc,
   .cfg_reg, .irq_control_reg, .file_rdata, .stack_top, .instr_done, .flush);
`default_nettype wire

// file: tb/return_interrupt_and_config_load_ops_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "retcfg_consts.svh"
module return_interrupt_and_config_load_ops_bench
   import retcfg_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   instr_t instr = '0;
   logic [7:0] w_reg = 8'h00;
   file_access_t file_acc = '0;
   pc_ctrl_t pc_in = '0;
   logic [12:0] pc, stack_top;
   logic [7:0] cfg_reg, irq_control_reg, file_rdata;
   logic global_irq_enable, file_hit, instr_done, flush;
   logic [20:0] notes[$];
   logic [12:0] stk[$];
   logic [7:0] cfg_m = `CFG_REG_RESET;
   logic [7:0] rdata_m = 8'h00;
   logic gie_m = 1'b0;
   int fails = 0, n_compared = 0, cycles = 0, seed = 32'h7c7dac3a;
   always #5 clk = ~clk;
   return_interrupt_and_config_load_ops uut (.clk, .rst, .instr, .w_reg, .file_acc, .pc_in, .pc, .cfg_reg,
      .irq_control_reg, .global_irq_enable, .file_rdata, .file_hit, .stack_top, .instr_done, .flush);
   task automatic check(input string nm, input logic [20:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   // ====
   // Issue one instruction and note its retire value
   // Kind 0 interrupt return, 1 config load, 2 plain word with push
   task automatic op(input logic [1:0] kind, input logic wr);
      logic [7:0] w, d;
      logic [12:0] a, b, top, top_m;
      logic [13:0] word;
      logic hit, have;
      w = $random(seed);
      d = $random(seed);
      a = $random(seed);
      b = $random(seed);
      word = $random(seed);
      hit = $random(seed);
      top = 13'h0000;
      top_m = 13'h0000;
      if (word == `OPC_IRQ_RETURN || word == `OPC_CFG_LOAD)
      begin
         word = 14'h0000;
      end
      if (kind == 2'd0)
      begin
         word = `OPC_IRQ_RETURN;
      end
      else if (kind == 2'd1)
      begin
         word = `OPC_CFG_LOAD;
      end
      instr <= '{word, 1'b1};
      w_reg <= w;
      pc_in <= '{a, kind == 2'd2, b};
      file_acc <= '{wr, !wr, hit ? `CFG_REG_ADDR : 7'h02, d};
      if (hit && !wr)
      begin
         rdata_m = cfg_m;
      end
      if (hit && wr)
      begin
         cfg_m = d;
      end
      if (kind == 2'd1)
      begin
         cfg_m = w;
      end
      if (kind == 2'd0)
      begin
         top = stk.pop_back();
         gie_m = 1'b1;
      end
      have = stk.size() > 0;
      if (have)
      begin
         top_m = stk[$];
      end
      if (kind == 2'd2)
      begin
         stk.push_back(b);
      end
      notes.push_back((kind == 2'd0) ? {top + 13'h1, cfg_m} : {a, cfg_m});
      repeat ((kind == 2'd0) ? 7 : 3) @(posedge clk);
      @(negedge clk);
      check("irq_ctrl", 21'(irq_control_reg), 21'({gie_m, 7'h00}));
      check("irq_enable", 21'(global_irq_enable), 21'(gie_m));
      check("flush", 21'(flush), 21'(kind == 2'd0));
      check("file_hit", 21'(file_hit), 21'(hit));
      check("file_rdata", 21'(file_rdata), 21'(rdata_m));
      if (have)
      begin
         check("stack_top", 21'(stack_top), 21'(top_m));
      end
      @(posedge clk);
      $display("op done kind=%0d", kind);
   endtask : op
   always @(negedge clk)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         fails++;
         complete_run();
      end
      else if (instr_done === 1'b1)
      begin
         check("pc_cfg", {pc, cfg_reg}, notes.pop_front());
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      op(2'd2, 1'b0);
      op(2'd2, 1'b1);
      op(2'd1, 1'b0);
      op(2'd0, 1'b1);
      op(2'd1, 1'b1);
      op(2'd2, 1'b0);
      op(2'd0, 1'b0);
      op(2'd0, 1'b0);
      repeat (2) @(posedge clk);
      complete_run();
   end
endmodule : return_interrupt_and_config_load_ops_bench
`default_nettype wire
